// *** cmpc_pkg.sv ***
/*
 comparator control package: register indices, field positions, reset
 values and shared types. assumes an 8-bit register port.
*/
package cmpc_pkg;
    // register indices on the plain register port
    localparam logic [7:0] CTRL_ADDR = 8'h9b;
    localparam logic [7:0] MODE_ADDR = 8'h9d;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'ha0;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'ha1;
    // control register fields
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_OUT_BIT = 6;
    localparam int CTRL_RIF_BIT = 5;
    localparam int CTRL_FIF_BIT = 4;
    localparam int CTRL_HYP_LSB = 2;
    localparam int CTRL_HYN_LSB = 0;
    // mode register fields
    localparam int MODE_RIE_BIT = 5;
    localparam int MODE_FIE_BIT = 4;
    localparam int MODE_MD_LSB = 0;
    // values after reset
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] MODE_MD_RESET = 2'h2;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h3;
    // hysteresis codes
    typedef enum logic [1:0] {
        HYST_OFF = 2'h0,
        HYST_5MV = 2'h1,
        HYST_10MV = 2'h2,
        HYST_20MV = 2'h3
    } cmpc_hyst_e;
    // response modes, fastest first
    typedef enum logic [1:0] {
        RESP_FAST = 2'h0,
        RESP_MODE1 = 2'h1,
        RESP_MODE2 = 2'h2,
        RESP_SLOW = 2'h3
    } cmpc_resp_e;
    // settings sent to the analog comparator
    typedef struct packed {
        logic power_on;
        cmpc_resp_e resp_mode;
        cmpc_hyst_e pos_hyst;
        cmpc_hyst_e neg_hyst;
    } cmpc_analog_s;
    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cmpc_req_s;
endpackage

// *** cmpc_top.sv ***
/*
 comparator digital control: enable, hysteresis and response settings,
 synchronised and raw outputs, sticky edge flags, interrupt.
 assumes the analog result arrives asynchronously and the register
 master follows the one-cycle strobe protocol on ref_clk.
*/
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/100ps
// Notes on behaviour
// - latched output and raw asynchronous output
// - disabled: pin output low, supply off
// - mode field selects response time, power
// - low two bits hold hysteresis, negative field
// - positive hysteresis field set independently
// - falling transition sets falling flag
// - rising transition sets rising flag
// - flags sticky until software writes them
// - rising enable lets rising flag interrupt
// - falling enable lets falling flag interrupt
// - output state bit readable, read-only
// - enable bit one enables, zero disables
// - result offered to reset logic
// - mode codes fastest 00 to slowest 11
// - hysteresis codes off, 5, 10, 20 mV
module cmpc_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire cmpc_pkg::cmpc_req_s reg_req,
    output logic [7:0] reg_rdata,
    // analog comparator
    input wire logic cmp_raw_in,
    output cmpc_pkg::cmpc_analog_s analog_cfg,
    // outputs
    output logic latched_cmp_output,
    output logic raw_async_cmp_output,
    output logic cmp_reset_src,
    output logic irq
);
    import cmpc_pkg::*;

    logic cmp_enable_bit_ff;
    logic rise_edge_flag_ff;
    logic fall_edge_flag_ff;
    logic [1:0] pos_hysteresis_sel_ff;
    logic [1:0] neg_hysteresis_sel_ff;
    logic rise_irq_enable_ff;
    logic fall_irq_enable_ff;
    logic [1:0] resp_mode_ff;
    logic [1:0] irq_stat_ff;
    logic [1:0] irq_mask_ff;
    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;
    logic rise_evt;
    logic fall_evt;
    logic wr_ctrl;
    logic wr_mode;
    logic wr_stat;
    logic wr_mask;
    logic [7:0] nxt_rdata;

    ////////////////////////////////////////////////////////////////////
    // timing summary for the register port and the edge path:
    // - a write strobe lands at the edge that samples it
    // - a read strobe loads reg_rdata at that edge; it stands one cycle
    // - reg_rdata returns zero in every other cycle
    // - unmapped indices read zero and ignore writes
    // - the output state bit of the control register is read-only
    // - an input change shows on latched_cmp_output two edges later
    // - the edge flag sets at the third edge; irq follows combinationally
    // - disabling gates the synchroniser input, so a high result falls
    // hazards a user must know:
    // - enabling or retuning the analog part may give false edges;
    //   software clears both flags shortly after such a change
    // - writing the control register rewrites both flags directly,
    //   so a read-modify-write must carry the flag bits it wants kept
    // - an edge in the same cycle as a software clear wins

    ////////////////////////////////////////////////////////////////////
    // write decode, shared by every register
    function automatic logic wr_at(input cmpc_req_s r,
        input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction

    // register port decode
    assign wr_ctrl = wr_at(reg_req, CTRL_ADDR);
    assign wr_mode = wr_at(reg_req, MODE_ADDR);
    assign wr_stat = wr_at(reg_req, IRQ_STAT_ADDR);
    assign wr_mask = wr_at(reg_req, IRQ_MASK_ADDR);

    // enable and hysteresis fields
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cmp_enable_bit_ff <= CTRL_RESET[CTRL_EN_BIT];
            pos_hysteresis_sel_ff <= CTRL_RESET[CTRL_HYP_LSB +: 2];
            neg_hysteresis_sel_ff <= CTRL_RESET[CTRL_HYN_LSB +: 2];
        end else if (wr_ctrl) begin
            cmp_enable_bit_ff <= reg_req.wdata[CTRL_EN_BIT];
            pos_hysteresis_sel_ff <= reg_req.wdata[CTRL_HYP_LSB +: 2];
            neg_hysteresis_sel_ff <= reg_req.wdata[CTRL_HYN_LSB +: 2];
        end
    end

    // mode register: interrupt enables and response mode
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rise_irq_enable_ff <= 1'b0;
            fall_irq_enable_ff <= 1'b0;
            resp_mode_ff <= MODE_MD_RESET;
        end else if (wr_mode) begin
            rise_irq_enable_ff <= reg_req.wdata[MODE_RIE_BIT];
            fall_irq_enable_ff <= reg_req.wdata[MODE_FIE_BIT];
            resp_mode_ff <= reg_req.wdata[MODE_MD_LSB +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // two-flop synchroniser and previous sample
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            sync1_ff <= cmp_raw_in & cmp_enable_bit_ff;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    // edge events from the synchronised result
    assign rise_evt = sync2_ff & ~prev_ff;
    assign fall_evt = ~sync2_ff & prev_ff;

    // sticky edge flags; a new edge wins over a software clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rise_edge_flag_ff <= 1'b0;
            fall_edge_flag_ff <= 1'b0;
        end else begin
            if (rise_evt) begin
                rise_edge_flag_ff <= 1'b1;
            end else if (wr_ctrl) begin
                rise_edge_flag_ff <= reg_req.wdata[CTRL_RIF_BIT];
            end
            if (fall_evt) begin
                fall_edge_flag_ff <= 1'b1;
            end else if (wr_ctrl) begin
                fall_edge_flag_ff <= reg_req.wdata[CTRL_FIF_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt status: bit1 rising, bit0 falling, write one to clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_stat_ff <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == 1) ? rise_evt : fall_evt) begin
                    irq_stat_ff[i] <= 1'b1;
                end else if (wr_stat && reg_req.wdata[i]) begin
                    irq_stat_ff[i] <= 1'b0;
                end
            end
        end
    end

    // system interrupt mask
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_mask_ff <= IRQ_MASK_RESET;
        end else if (wr_mask) begin
            irq_mask_ff <= reg_req.wdata[1:0];
        end
    end

    // comparator request: flag with its enable, gated by mask
    assign irq = (rise_edge_flag_ff & rise_irq_enable_ff & irq_mask_ff[1])
        | (fall_edge_flag_ff & fall_irq_enable_ff & irq_mask_ff[0]);

    ////////////////////////////////////////////////////////////////////
    // read data, valid the cycle after the strobe
    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_req.addr == CTRL_ADDR) begin
            nxt_rdata = {cmp_enable_bit_ff, sync2_ff, rise_edge_flag_ff,
                fall_edge_flag_ff, pos_hysteresis_sel_ff,
                neg_hysteresis_sel_ff};
        end else if (reg_req.addr == MODE_ADDR) begin
            nxt_rdata = {2'h0, rise_irq_enable_ff, fall_irq_enable_ff,
                2'h0, resp_mode_ff};
        end else if (reg_req.addr == IRQ_STAT_ADDR) begin
            nxt_rdata = {6'h00, irq_stat_ff};
        end else if (reg_req.addr == IRQ_MASK_ADDR) begin
            nxt_rdata = {6'h00, irq_mask_ff};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.rd) begin
            reg_rdata <= nxt_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // analog settings; supply off while disabled
    assign analog_cfg.power_on = cmp_enable_bit_ff;
    assign analog_cfg.resp_mode = cmpc_resp_e'(resp_mode_ff);
    assign analog_cfg.pos_hyst = cmpc_hyst_e'(pos_hysteresis_sel_ff);
    assign analog_cfg.neg_hyst = cmpc_hyst_e'(neg_hysteresis_sel_ff);

    // outputs: latched from flops, raw path has no clock
    assign latched_cmp_output = sync2_ff;
    assign raw_async_cmp_output = cmp_raw_in & cmp_enable_bit_ff;
    assign cmp_reset_src = sync2_ff;
endmodule

// *** cmpc_asserts.sv ***
/*
 port checker for the comparator control block.
 assumes a single ref_clk domain with synchronous active-high rst.
*/
`timescale 1ns/100ps
module cmpc_chk
    import cmpc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // watched ports
    input wire cmpc_pkg::cmpc_req_s reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic cmp_raw_in,
    input wire cmpc_pkg::cmpc_analog_s analog_cfg,
    input wire logic latched_cmp_output,
    input wire logic raw_async_cmp_output,
    input wire logic cmp_reset_src,
    input wire logic irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic rie_ff, fie_ff;
    logic [1:0] msk_ff;
    logic [7:0] wd_ff;
    wire gated_in = cmp_raw_in & analog_cfg.power_on;
    // shadow of irq enables, mask and last write data
    always_ff @(posedge ref_clk) begin
        wd_ff <= reg_req.wdata;
        if (rst)
            {rie_ff, fie_ff, msk_ff} <= 4'h3;
        else if (reg_req.wr && reg_req.addr == MODE_ADDR)
            {rie_ff, fie_ff} <= reg_req.wdata[5:4];
        else if (reg_req.wr && reg_req.addr == IRQ_MASK_ADDR)
            msk_ff <= reg_req.wdata[1:0];
    end
    sequence s_ctrl_wr;
        reg_req.wr && reg_req.addr == CTRL_ADDR;
    endsequence
    sequence s_mode_wr;
        reg_req.wr && reg_req.addr == MODE_ADDR;
    endsequence
    a_raw_path: assert property (
        raw_async_cmp_output == gated_in) else $error("raw output wrong");
    a_sync_delay: assert property (
        !$past(rst) && !$past(rst, 2) |->
        latched_cmp_output == $past(gated_in, 2)) else $error("sync wrong");
    a_reset_src: assert property (
        cmp_reset_src == latched_cmp_output) else $error("reset src wrong");
    a_disabled_low: assert property (
        !analog_cfg.power_on |-> ##2 !latched_cmp_output)
        else $error("output not low when off");
    a_flag_hold: assert property (
        irq && !reg_req.wr |=> irq) else $error("irq dropped alone");
    a_rise_irq: assert property (
        $rose(latched_cmp_output) && rie_ff && msk_ff[1] && !reg_req.wr
        |=> irq) else $error("rise gave no irq");
    a_fall_irq: assert property (
        $fell(latched_cmp_output) && fie_ff && msk_ff[0] && !reg_req.wr
        |=> irq) else $error("fall gave no irq");
    a_irq_cause: assert property (
        irq |-> rie_ff && msk_ff[1] || fie_ff && msk_ff[0])
        else $error("irq without enable");
    a_ctrl_cfg: assert property (
        s_ctrl_wr |=> analog_cfg.power_on == wd_ff[7] &&
        {analog_cfg.pos_hyst, analog_cfg.neg_hyst} == wd_ff[3:0])
        else $error("control fields wrong");
    a_mode_cfg: assert property (
        s_mode_wr |=> analog_cfg.resp_mode == wd_ff[1:0])
        else $error("mode field wrong");
endmodule
bind cmpc_top cmpc_chk u_chk (.ref_clk(ref_clk), .rst(rst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .cmp_raw_in(cmp_raw_in),
    .analog_cfg(analog_cfg), .latched_cmp_output(latched_cmp_output),
    .raw_async_cmp_output(raw_async_cmp_output),
    .cmp_reset_src(cmp_reset_src), .irq(irq));

// *** tb.sv ***
/*
 self-checking bench for the comparator control block.
 assumes the checker is bound from its own file.
*/
`timescale 1ns/100ps
module tb
    import cmpc_pkg::*;
;
    logic ref_clk, rst, cmp_raw_in;
    cmpc_req_s req;
    logic [7:0] reg_rdata;
    cmpc_analog_s analog_cfg;
    logic latched_cmp_output, raw_async_cmp_output, cmp_reset_src, irq;
    int n_errors = 0;
    int samples_checked = 0;
    cmpc_top u_dut (.ref_clk(ref_clk), .rst(rst), .reg_req(req),
        .reg_rdata(reg_rdata), .cmp_raw_in(cmp_raw_in),
        .analog_cfg(analog_cfg), .latched_cmp_output(latched_cmp_output),
        .raw_async_cmp_output(raw_async_cmp_output),
        .cmp_reset_src(cmp_reset_src), .irq(irq));
    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;
    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(string nm, logic [7:0] e, logic [7:0] got);
        samples_checked++;
        if (got !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, got);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge ref_clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(string nm, logic [7:0] a, logic [7:0] e);
        @(posedge ref_clk);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1 chk(nm, e, reg_rdata);
    endtask
    task automatic t_reset;
        rd("ctrl", CTRL_ADDR, CTRL_RESET);
        rd("mode", MODE_ADDR, 8'h02);
        rd("mask", IRQ_MASK_ADDR, 8'h03);
        rd("stat", IRQ_STAT_ADDR, 8'h00);
        rd("unmapped", 8'h55, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_cfg;
        for (int i = 0; i < 4; i++) begin
            wr(CTRL_ADDR, 8'h40 | 8'(i * 3 + 3));
            wr(MODE_ADDR, 8'(i));
            cyc(0);
            chk("cfg", {2'b00, 2'(i), 2'(i), 2'(3 - i)}, {1'b0, analog_cfg});
            rd("ctrl_ro", CTRL_ADDR, 8'(i * 3 + 3));
        end
        $display("t_cfg done");
    endtask
    task automatic t_edge;
        wr(MODE_ADDR, 8'h30);
        wr(CTRL_ADDR, 8'h80);
        wr(IRQ_MASK_ADDR, 8'h01);
        cmp_raw_in <= 1'b1;
        cyc(4);
        chk("outs", 8'h07, {5'h0, cmp_reset_src, raw_async_cmp_output,
            latched_cmp_output});
        chk("masked", 8'h00, {7'h0, irq});
        rd("stat", IRQ_STAT_ADDR, 8'h02);
        wr(IRQ_MASK_ADDR, 8'h03);
        cyc(5);
        chk("irq_rise", 8'h01, {7'h0, irq});
        rd("ctrl_r", CTRL_ADDR, 8'he0);
        wr(IRQ_STAT_ADDR, 8'h02);
        rd("stat_clr", IRQ_STAT_ADDR, 8'h00);
        wr(CTRL_ADDR, 8'h80);
        cmp_raw_in <= 1'b0;
        cyc(0);
        chk("irq_clr", 8'h00, {7'h0, irq});
        cyc(4);
        chk("irq_fall", 8'h01, {7'h0, irq});
        rd("ctrl_f", CTRL_ADDR, 8'h90);
        rd("stat_f", IRQ_STAT_ADDR, 8'h01);
        wr(MODE_ADDR, 8'h20);
        cyc(0);
        chk("irq_off", 8'h00, {7'h0, irq});
        wr(CTRL_ADDR, 8'h00);
        cmp_raw_in <= 1'b1;
        cyc(4);
        chk("off", 8'h00, {5'h0, analog_cfg.power_on, raw_async_cmp_output,
            latched_cmp_output});
        $display("t_edge done");
    endtask
    // hang guard
    initial begin
        repeat (2000) @(posedge ref_clk);
        n_errors++;
        end_sim;
    end
    // main sequence
    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        cmp_raw_in = 1'b0;
        req = '0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset;
        t_cfg;
        t_edge;
        end_sim;
    end
endmodule
